// ---- core/nvrc_host.sv ----
// nvrc_host.sv: host bus controller driving the memory pins; runs plain
// reads and writes and the six-read store and recall sequences.
// assumes the memory pins are its only view of the part; cap_low comes
// from an outside comparator, asynchronous to sys_clk.
// Notes on behaviour
// [RULE1] recall: six reads ending at 0F0E
// [RULE2] each sequence step is chip-enable-controlled read
// [RULE3] device clears then recalls; host just waits
// [RULE4] no access until recall time elapses
// [RULE5] recall leaves nonvolatile array unchanged
// [RULE6] device latches recall request at power-up
// [RULE7] power-up recall lasts hardware recall time
// [RULE8] no write state when power-up recall ends
// [RULE9] low storage voltage ignores store and writes
// [RULE10] six addresses consecutive, in listed order
// [RULE11] write enable high through all six cycles
// [RULE12] store: same five, sixth read 0F0F
// [RULE13] intervening access aborts the sequence
// [RULE14] store disables part for store time
// [RULE15] output enable level does not matter
// [RULE16] detector restarts at first address afterwards
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defines.svh"
module nvrc_host #(
   parameter int unsigned SOFT_RECALL_CYC = `NVRC_US_CYC(`NVRC_SOFT_RECALL_US),
   parameter int unsigned POWER_UP_RECALL_CYC = `NVRC_US_CYC(`NVRC_POWER_UP_RECALL_US),
   parameter int unsigned STORE_CYC = `NVRC_US_CYC(`NVRC_STORE_US)
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire nvrc_pkg::nvrc_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_refused,
   input wire logic cap_low,
   output nvrc_pkg::nvrc_pins_s pins,
   input wire logic [7:0] data_in
);
   // cycle counter width and phase loads
   localparam logic [`NVRC_CNT_W-1:0] SETUP_N = `NVRC_CNT_W'(`NVRC_SETUP_CYC);
   localparam logic [`NVRC_CNT_W-1:0] ACTIVE_N = `NVRC_CNT_W'(`NVRC_ACTIVE_CYC);
   localparam logic [`NVRC_CNT_W-1:0] HOLD_N = `NVRC_CNT_W'(`NVRC_HOLD_CYC);
   localparam logic [`NVRC_CNT_W-1:0] SREC_N = `NVRC_CNT_W'(SOFT_RECALL_CYC);
   localparam logic [`NVRC_CNT_W-1:0] PREC_N = `NVRC_CNT_W'(POWER_UP_RECALL_CYC);
   localparam logic [`NVRC_CNT_W-1:0] STORE_N = `NVRC_CNT_W'(STORE_CYC);

   // a count expires when it reaches one
   function automatic logic cnt_done(input logic [`NVRC_CNT_W-1:0] c);
      cnt_done = (c <= `NVRC_CNT_W'(1));
   endfunction

   nvrc_pkg::nvrc_state_e state_q, state_d;
   logic [`NVRC_CNT_W-1:0] cnt_q, cnt_d; // phase timer
   nvrc_pkg::nvrc_req_s cur_q; // request being served
   logic [2:0] step_q; // sequence step index
   logic [2:0] cap_sync_q; // cap_low synchroniser, three stages
   logic cap_low_q; // filtered low-voltage level
   logic [12:0] seq_word; // table output for current step
   nvrc_pkg::nvrc_req_s cur_d; // request held after this edge
   logic [2:0] step_d; // step index after this edge

   // sequence address table
   nvrc_seq_rom u_rom (
      .sys_clk(sys_clk),
      .nrst(nrst),
      // fed the next index, so its registered word always matches step_q
      .idx(step_d),
      .store_sel(cur_d.op == nvrc_pkg::NVRC_OP_STORE),
      .word_q(seq_word)
   );

   // low-voltage input: level changes once stages two and three agree
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cap_sync_q <= 3'h7;
         cap_low_q <= 1'b1;
      end else begin
         cap_sync_q <= {cap_sync_q[1:0], cap_low};
         if (cap_sync_q[1] == cap_sync_q[2]) begin
            cap_low_q <= cap_sync_q[2];
         end
      end
   end

   // decodes of the current request
   wire is_seq = cur_q.op[1];
   wire is_write = (cur_q.op == nvrc_pkg::NVRC_OP_WRITE);
   wire last_step = (step_q == 3'(`NVRC_SEQ_LEN - 1));
   // RULE9 store and writes refused while storage voltage low
   wire refuse_new = cap_low_q && (req.op == nvrc_pkg::NVRC_OP_WRITE ||
                                   req.op == nvrc_pkg::NVRC_OP_STORE);
   wire take = (state_q == nvrc_pkg::NVRC_ST_IDLE) && req_valid;
   wire [`NVRC_CNT_W-1:0] nv_time =
      (cur_q.op == nvrc_pkg::NVRC_OP_STORE) ? STORE_N : SREC_N;
   // sequence moves on when a step's hold phase ends
   wire step_adv = (state_q == nvrc_pkg::NVRC_ST_HOLD) && cnt_done(cnt_q) && is_seq &&
                   !last_step;
   // next request, shared by registers, table and pin decode
   assign cur_d = take ? req : cur_q;
   // RULE16 every sequence starts at the first address
   assign step_d = take ? 3'h0 : (step_adv ? step_q + 3'h1 : step_q);

   // next-state logic
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (!cnt_done(cnt_q)) begin
         cnt_d = cnt_q - `NVRC_CNT_W'(1);
      end
      case (state_q)
         // RULE7 wait out power-up recall before any access
         nvrc_pkg::NVRC_ST_POWER: begin
            if (cnt_done(cnt_q)) begin
               state_d = nvrc_pkg::NVRC_ST_IDLE;
            end
         end
         nvrc_pkg::NVRC_ST_IDLE: begin
            if (take && !refuse_new) begin
               state_d = nvrc_pkg::NVRC_ST_SETUP;
               cnt_d = SETUP_N;
            end
         end
         // plain-access address settles with chip enable high; a sequence address reaches the pins on the edge chip enable falls
         nvrc_pkg::NVRC_ST_SETUP: begin
            if (cnt_done(cnt_q)) begin
               state_d = nvrc_pkg::NVRC_ST_ACTIVE;
               cnt_d = ACTIVE_N;
            end
         end
         nvrc_pkg::NVRC_ST_ACTIVE: begin
            if (cnt_done(cnt_q)) begin
               state_d = nvrc_pkg::NVRC_ST_HOLD;
               cnt_d = HOLD_N;
            end
         end
         nvrc_pkg::NVRC_ST_HOLD: begin
            if (cnt_done(cnt_q)) begin
               // RULE10 steps follow back to back
               if (is_seq && !last_step) begin
                  state_d = nvrc_pkg::NVRC_ST_SETUP;
                  cnt_d = SETUP_N;
               // RULE4 RULE14 hold off for nonvolatile cycle
               end else if (is_seq) begin
                  state_d = nvrc_pkg::NVRC_ST_BUSY;
                  cnt_d = nv_time;
               end else begin
                  state_d = nvrc_pkg::NVRC_ST_IDLE;
               end
            end
         end
         nvrc_pkg::NVRC_ST_BUSY: begin
            if (cnt_done(cnt_q)) begin
               state_d = nvrc_pkg::NVRC_ST_IDLE;
            end
         end
         default: begin
            state_d = nvrc_pkg::NVRC_ST_IDLE;
         end
      endcase
   end

   // state and timer registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         // RULE6 reset stands for the power-up recall request
         state_q <= nvrc_pkg::NVRC_ST_POWER;
         cnt_q <= PREC_N;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // request capture and step counter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cur_q <= '0;
         step_q <= 3'h0;
      end else begin
         cur_q <= cur_d;
         step_q <= step_d;
      end
   end

   // pin drive, all registered
   wire in_cycle = (state_q == nvrc_pkg::NVRC_ST_ACTIVE);
   // decoded from the request held after this edge, so a take never
   // launches pins with the previous request's kind or data
   wire is_seq_d = cur_d.op[1];
   wire is_write_d = (cur_d.op == nvrc_pkg::NVRC_OP_WRITE);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         // RULE8 write enable held high through power-up recall
         pins <= '{chip_en_n: 1'b1, write_en_n: 1'b1, out_en_n: 1'b1,
                   word_select: 13'h0000, data_out: 8'h00, data_oe: 1'b0};
      end else begin
         // RULE2 chip enable frames each step, address stable while it is low
         pins.chip_en_n <= !(state_d == nvrc_pkg::NVRC_ST_ACTIVE);
         // RULE11 write enable stays high on sequence reads
         pins.write_en_n <= !(state_d == nvrc_pkg::NVRC_ST_ACTIVE && is_write_d);
         // RULE15 output enable not needed for sequence reads
         pins.out_en_n <= !(state_d == nvrc_pkg::NVRC_ST_ACTIVE && !is_seq_d && !is_write_d);
         // RULE1 RULE12 sequence addresses from table
         pins.word_select <= is_seq_d ? seq_word : cur_d.word;
         pins.data_out <= cur_d.wdata;
         pins.data_oe <= (state_d != nvrc_pkg::NVRC_ST_IDLE) && is_write_d &&
                         (state_d != nvrc_pkg::NVRC_ST_BUSY);
      end
   end

   // user-side answers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_refused <= 1'b0;
      end else begin
         req_ready <= (state_d == nvrc_pkg::NVRC_ST_IDLE) && !take;
         rsp_refused <= take && refuse_new;
         // RULE13 no other access can slip into a sequence
         rsp_valid <= (take && refuse_new) ||
                      ((state_q == nvrc_pkg::NVRC_ST_HOLD) && cnt_done(cnt_q) && !is_seq) ||
                      ((state_q == nvrc_pkg::NVRC_ST_BUSY) && cnt_done(cnt_q));
         // read data caught at end of the active phase
         if (in_cycle && cnt_done(cnt_q) && !is_seq && !is_write) begin
            rsp_data <= data_in;
         end
      end
   end
   // RULE3 RULE5 device-internal; host only times them
endmodule
`default_nettype wire

// ---- common/nvrc_defines.svh ----
// nvrc_defines.svh: offsets, sequence addresses and timing counts for the
// host-side controller of the nonvolatile static memory.
// assumes a 100 MHz sys_clk; included by bare name.
`ifndef NVRC_DEFINES_SVH
`define NVRC_DEFINES_SVH

// clock period in ns
`define NVRC_CLK_NS 10
// initiation sequence word addresses
`define NVRC_SEQ_A0 13'h0000
`define NVRC_SEQ_A1 13'h1555
`define NVRC_SEQ_A2 13'h0AAA
`define NVRC_SEQ_A3 13'h1FFF
`define NVRC_SEQ_A4 13'h10F0
`define NVRC_SEQ_RECALL 13'h0F0E
`define NVRC_SEQ_STORE 13'h0F0F
// pin cycle phases, ns
`define NVRC_SETUP_NS 10
`define NVRC_ACTIVE_NS 50
`define NVRC_HOLD_NS 10
// least cycles, rounded up
`define NVRC_SETUP_CYC ((`NVRC_SETUP_NS + `NVRC_CLK_NS - 1) / `NVRC_CLK_NS)
`define NVRC_ACTIVE_CYC ((`NVRC_ACTIVE_NS + `NVRC_CLK_NS - 1) / `NVRC_CLK_NS)
`define NVRC_HOLD_CYC ((`NVRC_HOLD_NS + `NVRC_CLK_NS - 1) / `NVRC_CLK_NS)
// nonvolatile cycle times, us (plain defaults)
`define NVRC_SOFT_RECALL_US 20
`define NVRC_POWER_UP_RECALL_US 550
`define NVRC_STORE_US 10000
`define NVRC_US_CYC(us) ((us) * 1000 / `NVRC_CLK_NS)
// counter width
`define NVRC_CNT_W 24
// sequence length
`define NVRC_SEQ_LEN 6

`endif

// ---- common/nvrc_pkg.sv ----
// nvrc_pkg.sv: types for the host-side controller of the memory.
// assumes nvrc_defines.svh is visible on the include path.
package nvrc_pkg;

   // kind of host request
   typedef enum logic [1:0] {
      NVRC_OP_READ = 2'b00,
      NVRC_OP_WRITE = 2'b01,
      NVRC_OP_STORE = 2'b10,
      NVRC_OP_RECALL = 2'b11
   } nvrc_op_e;

   // one user request
   typedef struct packed {
      nvrc_op_e op;
      logic [12:0] word;
      logic [7:0] wdata;
   } nvrc_req_s;

   // memory pin bundle driven by the host
   typedef struct packed {
      logic chip_en_n;
      logic write_en_n;
      logic out_en_n;
      logic [12:0] word_select;
      logic [7:0] data_out;
      logic data_oe;
   } nvrc_pins_s;

   // main sequencer states
   typedef enum logic [2:0] {
      NVRC_ST_POWER = 3'b000,
      NVRC_ST_IDLE = 3'b001,
      NVRC_ST_SETUP = 3'b010,
      NVRC_ST_ACTIVE = 3'b011,
      NVRC_ST_HOLD = 3'b100,
      NVRC_ST_BUSY = 3'b101
   } nvrc_state_e;

endpackage

// ---- core/nvrc_seq_rom.sv ----
// nvrc_seq_rom.sv: six-entry table of initiation sequence addresses.
// assumes a registered read is fine: caller waits one clock after index.
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defines.svh"
module nvrc_seq_rom (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [2:0] idx,
   input wire logic store_sel,
   output logic [12:0] word_q
);
   // combinational table lookup
   logic [12:0] word_d;
   always_comb begin
      case (idx)
         3'h0: word_d = `NVRC_SEQ_A0;
         3'h1: word_d = `NVRC_SEQ_A1;
         3'h2: word_d = `NVRC_SEQ_A2;
         3'h3: word_d = `NVRC_SEQ_A3;
         3'h4: word_d = `NVRC_SEQ_A4;
         // last step chooses the operation
         3'h5: word_d = store_sel ? `NVRC_SEQ_STORE : `NVRC_SEQ_RECALL;
         default: word_d = `NVRC_SEQ_A0;
      endcase
   end
   // registered read data
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         word_q <= 13'h0000;
      end else begin
         word_q <= word_d;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/nvrc_host_props.sv ----
// nvrc_host_props.sv: assertions on the host controller ports.
// assumes one clock domain; bound into every nvrc_host.
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defines.svh"
module nvrc_host_props #(
   parameter int unsigned SOFT_RECALL_CYC = 20,
   parameter int unsigned POWER_UP_RECALL_CYC = 20,
   parameter int unsigned STORE_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire nvrc_pkg::nvrc_req_s req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_refused,
   input wire logic cap_low,
   input wire nvrc_pkg::nvrc_pins_s pins,
   input wire logic [7:0] data_in
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   localparam logic [12:0] SEQ_W [5] = '{`NVRC_SEQ_A0, `NVRC_SEQ_A1, `NVRC_SEQ_A2,
      `NVRC_SEQ_A3, `NVRC_SEQ_A4};
   wire take = req_valid && req_ready;
   logic seq_q; // store or recall running
   logic st_q; // running op is a store
   logic ce_last_q; // chip enable one cycle ago
   logic [2:0] ce_q; // finished sequence steps
   logic [15:0] gap_q; // cycles since last step
   logic [15:0] pu_q; // cycles since reset release
   wire [12:0] exp_w = (ce_q < 3'h5) ? SEQ_W[ce_q] :
      (st_q ? `NVRC_SEQ_STORE : `NVRC_SEQ_RECALL);
   // tracking helpers; gap_q and pu_q saturate so long runs never wrap
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seq_q <= 1'b0;
         st_q <= 1'b0;
         ce_last_q <= 1'b1;
         ce_q <= 3'h0;
         gap_q <= 16'h0;
         pu_q <= 16'h0;
      end else begin
         ce_last_q <= pins.chip_en_n;
         if (pu_q != 16'hFFFF) pu_q <= pu_q + 16'h1;
         if (take) begin
            seq_q <= req.op[1];
            st_q <= !req.op[0];
            ce_q <= 3'h0;
         end else if (rsp_valid) begin
            seq_q <= 1'b0;
         end
         if (!ce_last_q && pins.chip_en_n) begin
            ce_q <= ce_q + 3'h1;
            gap_q <= 16'h0;
         end else if (gap_q != 16'hFFFF) begin
            gap_q <= gap_q + 16'h1;
         end
      end
   end
   // one chip-enable-controlled read step
   sequence ce_read_s;
      (!pins.chip_en_n && pins.write_en_n)[*5] ##1 pins.chip_en_n;
   endsequence
   AST_SEQ_ADDR: assert property (
      seq_q && $fell(pins.chip_en_n) |-> pins.word_select == exp_w)
      else $error("sequence address out of order");
   AST_SEQ_STEP: assert property (
      seq_q && $fell(pins.chip_en_n) |-> ce_read_s)
      else $error("sequence step is not a read");
   AST_SEQ_WE: assert property (
      seq_q |-> pins.write_en_n && !pins.data_oe)
      else $error("write enable low in sequence");
   AST_SEQ_QUIET: assert property (
      seq_q && ce_q == 3'h6 |-> pins.chip_en_n)
      else $error("access during nonvolatile cycle");
   AST_NV_WAIT: assert property (
      seq_q && rsp_valid && !rsp_refused |-> gap_q >= (st_q ? STORE_CYC : SOFT_RECALL_CYC))
      else $error("nonvolatile cycle cut short");
   AST_PU_QUIET: assert property (
      pu_q < 16'(POWER_UP_RECALL_CYC) |-> pins.chip_en_n && pins.write_en_n)
      else $error("pins moved during power-up recall");
   AST_REFUSE: assert property (
      cap_low[*5] ##0 (take && (req.op == nvrc_pkg::NVRC_OP_WRITE ||
      req.op == nvrc_pkg::NVRC_OP_STORE)) |=> rsp_valid && rsp_refused ##0 pins.chip_en_n)
      else $error("write or store not refused");
   AST_IDLE_PINS: assert property (
      req_ready |-> pins.chip_en_n && pins.write_en_n)
      else $error("stray access while idle");
endmodule
bind nvrc_host nvrc_host_props #(.SOFT_RECALL_CYC(SOFT_RECALL_CYC),
   .POWER_UP_RECALL_CYC(POWER_UP_RECALL_CYC), .STORE_CYC(STORE_CYC)) i_nvrc_host_props (
   .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused),
   .cap_low(cap_low), .pins(pins), .data_in(data_in));
`default_nettype wire

// ---- testbench/nvrc_mem_model.sv ----
// nvrc_mem_model.sv: behavioural memory with nonvolatile shadow.
// assumes host pins registered to sys_clk; keeps words 0..7 only.
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defines.svh"
module nvrc_mem_model #(
   parameter int unsigned PU_CYC = 20,
   parameter int unsigned RC_CYC = 20,
   parameter int unsigned ST_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cap_low,
   input wire nvrc_pkg::nvrc_pins_s pins,
   output logic [7:0] data_in,
   output logic viol
);
   localparam logic [12:0] SEQ_W [5] = '{`NVRC_SEQ_A0, `NVRC_SEQ_A1, `NVRC_SEQ_A2,
      `NVRC_SEQ_A3, `NVRC_SEQ_A4};
   logic [7:0] sram_q [8];
   logic [7:0] nv_q [8];
   logic [2:0] idx_q; // sequence progress
   logic [15:0] busy_q; // cycles left of nv cycle
   logic ce_q;
   logic we_q; // write enable one cycle ago: host lifts it with chip enable
   logic [7:0] last_q; // released bus shows its inverse
   wire [12:0] ws = pins.word_select;
   wire ce_end = !ce_q && pins.chip_en_n;
   wire hit = idx_q < 3'h5 && ws == SEQ_W[idx_q];
   wire drive = !pins.chip_en_n && !pins.out_en_n && busy_q == 16'h0;
   assign data_in = pins.data_oe ? pins.data_out : (drive ? sram_q[ws[2:0]] : ~last_q);
   initial for (int i = 0; i < 8; i++) nv_q[i] = 8'h00;
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         busy_q <= 16'(PU_CYC);
         idx_q <= 3'h0;
         ce_q <= 1'b1;
         we_q <= 1'b1;
         viol <= 1'b0;
         for (int i = 0; i < 8; i++) sram_q[i] <= nv_q[i];
      end else begin
         ce_q <= pins.chip_en_n;
         we_q <= pins.write_en_n;
         last_q <= data_in;
         if (busy_q != 16'h0) begin
            busy_q <= busy_q - 16'h1;
            if (!pins.chip_en_n || !pins.write_en_n) viol <= 1'b1;
         end else if (ce_end && !we_q) begin
            idx_q <= 3'h0;
            if (!cap_low) sram_q[ws[2:0]] <= pins.data_out;
         end else if (ce_end) begin
            idx_q <= hit ? idx_q + 3'h1 : {2'b00, ws == `NVRC_SEQ_A0};
            if (idx_q == 3'h5 && ws == `NVRC_SEQ_RECALL) begin
               busy_q <= 16'(RC_CYC);
               for (int i = 0; i < 8; i++) sram_q[i] <= nv_q[i];
            end
            if (idx_q == 3'h5 && ws == `NVRC_SEQ_STORE && !cap_low) begin
               busy_q <= 16'(ST_CYC);
               for (int i = 0; i < 8; i++) nv_q[i] <= sram_q[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/nvrc_host_tb.sv ----
// nvrc_host_tb.sv: self-checking bench for the host controller.
// assumes short nv counts of 20 cycles; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
module nvrc_host_tb;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic cap_low = 1'b0;
   nvrc_pkg::nvrc_req_s req = '0;
   logic req_ready, rsp_valid, rsp_refused, viol;
   logic [7:0] rsp_data, data_in, rd_q;
   logic ref_q;
   nvrc_pkg::nvrc_pins_s pins;
   int miscompares = 0;
   int n_compared = 0;
   always #5 sys_clk = ~sys_clk;
   nvrc_host #(.SOFT_RECALL_CYC(20), .POWER_UP_RECALL_CYC(20), .STORE_CYC(20)) i_nvrc_host (
      .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_refused(rsp_refused), .cap_low(cap_low), .pins(pins), .data_in(data_in));
   nvrc_mem_model i_nvrc_mem_model (.sys_clk(sys_clk), .nrst(nrst), .cap_low(cap_low),
      .pins(pins), .data_in(data_in), .viol(viol));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one request; waits are bounded, a hang ends the run
   task automatic do_op(input nvrc_pkg::nvrc_op_e op, input logic [12:0] w,
      input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      req_valid = 1'b1;
      req = '{op: op, word: w, wdata: d};
      @(negedge sys_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 5000) begin
         miscompares++;
         final_report();
      end
      ref_q = rsp_refused;
      rd_q = rsp_data;
   endtask
   task automatic t_store_recall;
      do_op(nvrc_pkg::NVRC_OP_WRITE, 13'h0004, 8'h5A);
      do_op(nvrc_pkg::NVRC_OP_STORE, 13'h0000, 8'h00);
      check({7'h00, ref_q}, 8'h00);
      do_op(nvrc_pkg::NVRC_OP_WRITE, 13'h0004, 8'h00);
      for (int i = 0; i < 2; i++) begin
         do_op(nvrc_pkg::NVRC_OP_RECALL, 13'h0000, 8'h00);
         do_op(nvrc_pkg::NVRC_OP_READ, 13'h0004, 8'h00);
         check(rd_q, 8'h5A);
      end
   endtask
   task automatic t_cap_low;
      cap_low = 1'b1;
      repeat (6) @(negedge sys_clk);
      do_op(nvrc_pkg::NVRC_OP_WRITE, 13'h0004, 8'h33);
      check({7'h00, ref_q}, 8'h01);
      do_op(nvrc_pkg::NVRC_OP_STORE, 13'h0000, 8'h00);
      check({7'h00, ref_q}, 8'h01);
      do_op(nvrc_pkg::NVRC_OP_RECALL, 13'h0000, 8'h00);
      check({7'h00, ref_q}, 8'h00);
      do_op(nvrc_pkg::NVRC_OP_READ, 13'h0004, 8'h00);
      check(rd_q, 8'h5A);
      cap_low = 1'b0;
      repeat (6) @(negedge sys_clk);
   endtask
   // second reset mid-run must bring back the stored word
   task automatic t_re_power;
      nrst = 1'b0;
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      do_op(nvrc_pkg::NVRC_OP_READ, 13'h0004, 8'h00);
      check(rd_q, 8'h5A);
   endtask
   initial begin
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      t_store_recall();
      t_cap_low();
      check({7'h00, viol}, 8'h00);
      t_re_power();
      check({7'h00, viol}, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
